/* logic/psc_defines.vh */
// Constants for the power-save clock and short chip-select block.
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

`define PSC_IDX_GCS        8'h00
`define PSC_IDX_PSC        8'h0d
`define PSC_IDX_IST        8'h10
`define PSC_IDX_ICLR       8'h11
`define PSC_IDX_IEN        8'h12

`define PSC_ST_HI          7
`define PSC_ST_LO          5
`define PSC_RS_BIT         4
`define PSC_WS_BIT         3
`define PSC_DV_HI          2
`define PSC_DV_LO          0
`define PSC_CODE_ON_BIT    2

`define GCS_STAT_HI        7
`define GCS_STAT_LO        6
`define GCS_FORCE_BIT      5
`define GCS_SEL_HI         4
`define GCS_SEL_LO         2
`define GCS_PRI_HI         1
`define GCS_PRI_LO         0

`define GCS_STAT_NONE      2'h0
`define GCS_STAT_WDOG      2'h1
`define GCS_STAT_RESET     2'h3

`define SEL_OSC8           3'h0
`define SEL_PERI_FAST      3'h1
`define SEL_FULL           3'h2
`define SEL_OSC2           3'h3
`define SEL_SLOW           3'h4
`define SEL_SLOW_OFF       3'h5
`define SEL_OSC4           3'h6
`define SEL_OSC6           3'h7

`define DV_BY2             3'h4
`define DV_BY4             3'h5
`define DV_BY8             3'h6
`define DV_BY16            3'h7

`define DIV_1              5'h01
`define DIV_2              5'h02
`define DIV_4              5'h04
`define DIV_6              5'h06
`define DIV_8              5'h08
`define DIV_16             5'h10

`define ST_296             3'h4
`define ST_234             3'h5
`define ST_171             3'h6
`define ST_109             3'h7
`define ST_NS_296          296
`define ST_NS_234          234
`define ST_NS_171          171
`define ST_NS_109          109
`define CLK_PERIOD_NS      100
`define NS_TO_CYC(ns)      (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define SHORT_FAST_UNITS   4'h2
`define SHORT_SLOW_UNITS   4'h1

`define PSC_RST            8'h00
`define GCS_SEL_RST        3'h0
`define GCS_PRI_RST        2'h0

`define IRQ_W              3
`define IRQ_WDOG           0
`define IRQ_RSVD           1
`define IRQ_FORCE          2

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* logic/psc_clk_div.v */
// Run-time programmable divider that emits one tick per divisor input steps.
`timescale 1ns/1ps
`default_nettype none
module psc_clk_div #(
  parameter W = 5
) (
  input  wire         clk_sys,
  input  wire         reset,
  input  wire         stepIn,
  input  wire [W-1:0] divisor,
  output reg          tickOut
);
  reg [W-1:0] count_q;

  // A divisor shrunk mid-count ends the count on the next input step rather than wrapping.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= {W{1'b0}};
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (stepIn) begin
        if (count_q + {{(W-1){1'b0}}, 1'b1} >= divisor) begin
          count_q <= {W{1'b0}};
          tickOut <= 1'b1;
        end else begin
          count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // psc_clk_div
`default_nettype wire

/* logic/psc_top.v */
// Clock select, power save, short chip-select timing and status registers.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.vh"
module psc_top #(
  parameter AW = 12
) (
  input  wire          clk_sys,
  input  wire          reset,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          osc32In,
  input  wire          wdTimeout,
  input  wire          busCsReq,
  input  wire          busRead,
  input  wire          busWrite,
  input  wire          busWrStrobe,
  input  wire          busSecondState,
  output reg           cpuClkEn,
  output reg           periClkEn,
  output reg           mainOscEn,
  output reg           slowClkMode,
  output reg           periodicForce,
  output reg  [1:0]    periodicPriority,
  output reg           csOut,
  output reg           wrStrobeOut,
  output reg           busStall,
  output reg           irq
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_SELF  = 3'h1;
  localparam ST_RDSH  = 3'h2;
  localparam ST_WPRE  = 3'h3;
  localparam ST_WPOST = 3'h4;
  localparam ST_WAIT  = 3'h5;

  reg  [7:0]        psc_q;
  reg  [2:0]        clkSel_q;
  reg  [1:0]        pri_q;
  reg  [1:0]        stat_q;
  reg  [`IRQ_W-1:0] ist_q;
  reg  [`IRQ_W-1:0] ien_q;
  reg  [`IRQ_W-1:0] ist_d;
  reg  [AW-1:0]     awAddr_q;
  reg  [7:0]        wByte_q;
  reg               wLane0_q;
  reg               awHave_q;
  reg               wHave_q;
  reg               osc32Meta_q;
  reg               osc32Sync_q;
  reg               osc32Sync2_q;
  reg               osc32Stable_q;
  reg  [2:0]        state_q;
  reg  [2:0]        state_d;
  reg  [3:0]        cnt_q;
  reg  [3:0]        cnt_d;
  reg               cs_d;
  reg               wr_d;
  reg               wrPrev_q;
  reg  [4:0]        fastDiv;
  reg  [4:0]        slowDiv;
  reg  [3:0]        selfCyc;
  reg  [31:0]       selfCycFull;
  reg  [31:0]       rdWord;
  reg               rdHit;
  wire [7:0]        wIdx;
  wire [7:0]        rIdx;
  wire              wrFire;
  wire              rdFire;
  wire              rdGcs;
  wire              osc32Edge;
  wire              fastTick;
  wire              slowTick;
  wire              slowMode;
  wire              shortOk;
  wire              selfOk;
  wire              unitTick;
  wire [3:0]        unitLen;
  wire              wrFall;
  wire              rsvdWrite;
  wire              forceWrite;
  wire [`IRQ_W-1:0] events;

  assign wIdx   = awAddr_q[9:2];
  assign rIdx   = s_axi_araddr[9:2];
  assign wrFire = awHave_q && wHave_q && !s_axi_bvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign rdGcs  = rdFire && (rIdx == `PSC_IDX_GCS);

  // AXI4-Lite write side: address and data are taken in either order.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= {AW{1'b0}};
      wByte_q       <= 8'h00;
      wLane0_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q      <= s_axi_awaddr;
        awHave_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wByte_q      <= s_axi_wdata[7:0];
        wLane0_q     <= s_axi_wstrb[0];
        wHave_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        case (wIdx)
          `PSC_IDX_GCS, `PSC_IDX_PSC, `PSC_IDX_ICLR, `PSC_IDX_IEN: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHave_q      <= 1'b0;
        wHave_q       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read mux; the status field is cleared by the same access that returns it.
  always @* begin
    rdWord = 32'h0000_0000;
    rdHit  = 1'b1;
    case (rIdx)
      `PSC_IDX_GCS: begin
        rdWord[`GCS_STAT_HI:`GCS_STAT_LO] = stat_q;
        rdWord[`GCS_SEL_HI:`GCS_SEL_LO]   = clkSel_q;
        rdWord[`GCS_PRI_HI:`GCS_PRI_LO]   = pri_q;
      end
      `PSC_IDX_PSC:  rdWord[7:0] = psc_q;
      `PSC_IDX_IST:  rdWord[`IRQ_W-1:0] = ist_q;
      `PSC_IDX_IEN:  rdWord[`IRQ_W-1:0] = ien_q;
      `PSC_IDX_ICLR: rdWord = 32'h0000_0000;
      default:       rdHit = 1'b0;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (rdFire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdWord;
        s_axi_rresp   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  assign forceWrite = wrFire && wLane0_q && (wIdx == `PSC_IDX_GCS) && wByte_q[`GCS_FORCE_BIT];
  assign rsvdWrite  = wrFire && wLane0_q && (wIdx == `PSC_IDX_PSC) &&
                      ((!wByte_q[`PSC_ST_HI] && (wByte_q[`PSC_ST_HI:`PSC_ST_LO] != 3'h0)) ||
                       (!wByte_q[`PSC_DV_HI] && (wByte_q[`PSC_DV_HI:`PSC_DV_LO] != 3'h0)));

  // Control registers; byte lane 0 carries the eight register bits.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      psc_q         <= `PSC_RST;
      clkSel_q      <= `GCS_SEL_RST;
      pri_q         <= `GCS_PRI_RST;
      ien_q         <= {`IRQ_W{1'b0}};
      periodicForce <= 1'b0;
    end else begin
      periodicForce <= forceWrite;
      if (wrFire && wLane0_q) begin
        case (wIdx)
          `PSC_IDX_PSC: psc_q <= wByte_q;
          `PSC_IDX_GCS: begin
            clkSel_q <= wByte_q[`GCS_SEL_HI:`GCS_SEL_LO];
            pri_q    <= wByte_q[`GCS_PRI_HI:`GCS_PRI_LO];
          end
          `PSC_IDX_IEN: ien_q <= wByte_q[`IRQ_W-1:0];
          default: ien_q <= ien_q;
        endcase
      end
    end
  end

  // A watchdog event in the reading cycle survives the clear; outside a read, reset code outranks it.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stat_q <= `GCS_STAT_RESET;
    end else if (wdTimeout) begin
      stat_q <= (stat_q == `GCS_STAT_RESET && !rdGcs) ? `GCS_STAT_RESET : `GCS_STAT_WDOG;
    end else if (rdGcs) begin
      stat_q <= `GCS_STAT_NONE;
    end
  end

  assign events = {forceWrite, rsvdWrite, wdTimeout};

  always @* begin
    ist_d = ist_q | events;
    if (wrFire && wLane0_q && (wIdx == `PSC_IDX_ICLR)) begin
      ist_d = (ist_q & ~wByte_q[`IRQ_W-1:0]) | events;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ist_q <= {`IRQ_W{1'b0}};
      irq   <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq   <= |(ist_d & ien_q);
    end
  end

  // The slow oscillator pin is asynchronous; a rising edge counts once stages two and three agree.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      osc32Meta_q   <= 1'b0;
      osc32Sync_q   <= 1'b0;
      osc32Sync2_q  <= 1'b0;
      osc32Stable_q <= 1'b0;
    end else begin
      osc32Meta_q  <= osc32In;
      osc32Sync_q  <= osc32Meta_q;
      osc32Sync2_q <= osc32Sync_q;
      if (osc32Sync_q == osc32Sync2_q) begin
        osc32Stable_q <= osc32Sync2_q;
      end
    end
  end

  assign osc32Edge = (osc32Sync_q == osc32Sync2_q) && osc32Sync2_q && !osc32Stable_q;

  // Reserved divider codes behave as the disabled code: the undivided slow clock.
  always @* begin
    case (psc_q[`PSC_DV_HI:`PSC_DV_LO])
      `DV_BY2:  slowDiv = `DIV_2;
      `DV_BY4:  slowDiv = `DIV_4;
      `DV_BY8:  slowDiv = `DIV_8;
      `DV_BY16: slowDiv = `DIV_16;
      default:  slowDiv = `DIV_1;
    endcase
    case (clkSel_q)
      `SEL_OSC8, `SEL_PERI_FAST: fastDiv = `DIV_8;
      `SEL_OSC2:                 fastDiv = `DIV_2;
      `SEL_OSC4:                 fastDiv = `DIV_4;
      `SEL_OSC6:                 fastDiv = `DIV_6;
      default:                   fastDiv = `DIV_1;
    endcase
    case (psc_q[`PSC_ST_HI:`PSC_ST_LO])
      `ST_296: selfCycFull = `NS_TO_CYC(`ST_NS_296);
      `ST_234: selfCycFull = `NS_TO_CYC(`ST_NS_234);
      `ST_171: selfCycFull = `NS_TO_CYC(`ST_NS_171);
      `ST_109: selfCycFull = `NS_TO_CYC(`ST_NS_109);
      default: selfCycFull = 32'h0000_0000;
    endcase
    // The cycle count is computed in integer width; all codes fit in four bits.
    selfCyc = selfCycFull[3:0];
  end

  psc_clk_div #(.W(5)) uFastDiv (
    .clk_sys (clk_sys),
    .reset   (reset),
    .stepIn  (1'b1),
    .divisor (fastDiv),
    .tickOut (fastTick)
  );

  psc_clk_div #(.W(5)) uSlowDiv (
    .clk_sys (clk_sys),
    .reset   (reset),
    .stepIn  (osc32Edge),
    .divisor (slowDiv),
    .tickOut (slowTick)
  );

  assign slowMode = (clkSel_q == `SEL_SLOW) || (clkSel_q == `SEL_SLOW_OFF);
  assign shortOk  = (clkSel_q != `SEL_FULL);
  assign selfOk   = slowMode && psc_q[`PSC_ST_HI];
  assign unitTick = slowMode ? slowTick : 1'b1;
  assign unitLen  = slowMode ? `SHORT_SLOW_UNITS : `SHORT_FAST_UNITS;
  assign wrFall   = wrPrev_q && !busWrStrobe;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cpuClkEn         <= 1'b0;
      periClkEn        <= 1'b0;
      mainOscEn        <= 1'b1;
      slowClkMode      <= 1'b0;
      periodicPriority <= `GCS_PRI_RST;
    end else begin
      cpuClkEn         <= slowMode ? slowTick : fastTick;
      periClkEn        <= (clkSel_q == `SEL_PERI_FAST) ? 1'b1 :
                          (slowMode ? slowTick : fastTick);
      mainOscEn        <= (clkSel_q != `SEL_SLOW_OFF);
      slowClkMode      <= slowMode;
      periodicPriority <= pri_q;
    end
  end

  // Chip-select shaping. Each strobe fires once per request and then waits for the
  // request to drop, so a long cycle cannot retrigger it.
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    cs_d    = 1'b0;
    wr_d    = busWrStrobe;
    case (state_q)
      ST_IDLE: begin
        if (busCsReq) begin
          if (selfOk) begin
            state_d = ST_SELF;
            cnt_d   = selfCyc;
            cs_d    = 1'b1;
          end else if (busWrite && psc_q[`PSC_WS_BIT] && shortOk) begin
            if (wrFall) begin
              state_d = ST_WPRE;
              cnt_d   = 4'h0;
              cs_d    = 1'b1;
              wr_d    = 1'b1;
            end
          end else if (busRead && psc_q[`PSC_RS_BIT] && shortOk) begin
            if (busSecondState) begin
              state_d = ST_RDSH;
              cnt_d   = 4'h0;
              cs_d    = 1'b1;
            end
          end else begin
            cs_d = 1'b1;
          end
        end
      end
      ST_SELF: begin
        cs_d  = 1'b1;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q <= 4'h1) begin
          state_d = ST_WAIT;
          cs_d    = 1'b0;
        end
      end
      ST_RDSH: begin
        cs_d = 1'b1;
        if (unitTick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= unitLen) begin
            state_d = ST_WAIT;
            cs_d    = 1'b0;
          end
        end
      end
      ST_WPRE: begin
        cs_d = 1'b1;
        wr_d = 1'b1;
        if (unitTick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= unitLen) begin
            state_d = ST_WPOST;
            cnt_d   = 4'h0;
            wr_d    = 1'b0;
          end
        end
      end
      ST_WPOST: begin
        cs_d = 1'b1;
        wr_d = 1'b0;
        if (unitTick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= unitLen) begin
            state_d = ST_WAIT;
            cs_d    = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (!busCsReq) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // The write strobe is held until the leading chip-select half is done, so the
  // bus unit is stalled meanwhile; this lengthens the cycle but keeps the edge timing.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'h0;
      csOut       <= 1'b0;
      wrStrobeOut <= 1'b0;
      wrPrev_q    <= 1'b0;
      busStall    <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      csOut       <= cs_d;
      wrStrobeOut <= wr_d;
      wrPrev_q    <= busWrStrobe;
      busStall    <= (state_d == ST_WPRE);
    end
  end
endmodule // psc_top
`default_nettype wire

/* tb/psc_top_chk.sv */
// Port-level checks for the power-save clock and chip-select block.
`timescale 1ns/1ps
`default_nettype none
module psc_top_chk #(
  parameter AW = 12
) (
  input wire logic          clk_sys,
  input wire logic          reset,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  input wire logic          mainOscEn,
  input wire logic          slowClkMode,
  input wire logic          periodicForce,
  input wire logic          csOut,
  input wire logic          wrStrobeOut,
  input wire logic          busStall
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [AW-1:0] rdAddrQ;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) rdAddrQ <= '0;
    else if (s_axi_arvalid && s_axi_arready) rdAddrQ <= s_axi_araddr;
  end
  sequence seqWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence seqCsTail;
    csOut ##1 csOut;
  endsequence
  AST_WR_RESP: assert property (seqWrTaken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_GCS_READ: assert property (
    s_axi_rvalid && rdAddrQ == '0 |-> s_axi_rdata[7:5] inside {3'h0, 3'h2, 3'h6})
    else $error("bad global status read");
  AST_OSC_OFF: assert property (!mainOscEn |-> slowClkMode)
    else $error("oscillator off in fast mode");
  AST_FORCE_PULSE: assert property (periodicForce |=> !periodicForce)
    else $error("force pulse too long");
  AST_STALL: assert property (busStall |-> wrStrobeOut)
    else $error("stall without held strobe");
  AST_WR_TAIL: assert property ($fell(wrStrobeOut) && $past(busStall) |-> seqCsTail)
    else $error("write select tail short");
endmodule // psc_top_chk
bind psc_top psc_top_chk #(.AW(AW)) psc_top_chk_i (.clk_sys, .reset, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .mainOscEn,
  .slowClkMode, .periodicForce, .csOut, .wrStrobeOut, .busStall);
`default_nettype wire

/* tb/psc_mem_model.sv */
// Far-side memory model that measures the chip-select strobes it receives.
`timescale 1ns/1ps
`default_nettype none
module psc_mem_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic csOut,
  input wire logic wrStrobeOut,
  output var int   csLen,
  output var int   csAtFall
);
  int   runQ;
  logic wrQ;
  // The block gives the device no data path, so only the strobe shape is kept.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      runQ <= 0;
      csLen <= 0;
      csAtFall <= 0;
      wrQ <= 0;
    end else begin
      wrQ <= wrStrobeOut;
      runQ <= csOut ? runQ + 1 : 0;
      if (!csOut && runQ != 0) csLen <= runQ;
      if (wrQ && !wrStrobeOut) csAtFall <= runQ;
    end
  end
endmodule // psc_mem_model
`default_nettype wire

/* tb/power_save_clock_and_short_cs_bench.sv */
// Self-checking bench for the power-save clock and short chip-select block.
`timescale 1ns/1ps
`default_nettype none
module power_save_clock_and_short_cs_bench;
  logic        clk_sys = 0, reset = 1, osc32In = 0, wdTimeout = 0;
  logic [11:0] awA = 0, arA = 0;
  logic [31:0] wD = 0, rs = 32'h61, c, p, tmp;
  logic        awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
  logic        busCsReq = 0, busRead = 0, busWrite = 0, busWrStrobe = 0, busSecondState = 0;
  logic [7:0]  rd, dvB;
  logic [1:0]  resp;
  wire         awR, wR, bV, arR, rV, cpuClkEn, periClkEn, mainOscEn, slowClkMode;
  wire         periodicForce, csOut, wrStrobeOut, busStall, irq;
  wire  [1:0]  bResp, rResp, periodicPriority;
  wire  [31:0] rData;
  int          failCount = 0, testsRun = 0, forceCnt = 0, csLen, csAtFall, per;
  psc_top #(.AW(12)) psc_top_i (.clk_sys, .reset, .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
    .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .osc32In, .wdTimeout,
    .busCsReq, .busRead, .busWrite, .busWrStrobe, .busSecondState, .cpuClkEn, .periClkEn,
    .mainOscEn, .slowClkMode, .periodicForce, .periodicPriority, .csOut, .wrStrobeOut,
    .busStall, .irq);
  psc_mem_model psc_mem_model_i (.clk_sys, .reset, .csOut, .wrStrobeOut, .csLen, .csAtFall);
  always #50 clk_sys = ~clk_sys;
  // A fast stand-in for the slow oscillator keeps slow-mode runs short: 20 cycles a period.
  always begin
    repeat (10) @(posedge clk_sys);
    osc32In <= ~osc32In;
  end
  always @(posedge clk_sys) if (periodicForce === 1'b1) forceCnt++;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic int dv(int s);
    case (s)
      2: return 1;
      3: return 2;
      6: return 4;
      7: return 6;
      default: return 8;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic completeRun();
    $display("comparisons %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    awA <= {2'h0, idx, 2'h0};
    wD <= {24'h0, d};
    awV <= 1;
    wV <= 1;
    bRdy <= 1;
    do begin
      @(posedge clk_sys);
      if (awR) awV <= 0;
      if (wR) wV <= 0;
    end while (!bV);
    bRdy <= 0;
    chk(bResp, 2'h0);
  endtask
  task automatic chkRd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge clk_sys);
    arA <= {2'h0, idx, 2'h0};
    arV <= 1;
    rRdy <= 1;
    do begin
      @(posedge clk_sys);
      if (arR) arV <= 0;
    end while (!rV);
    rRdy <= 0;
    chk(rResp, er);
    chk(rData, {24'h0, e});
  endtask
  task automatic cnt(input int n);
    repeat (n) @(posedge clk_sys);
    c = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk_sys);
      c += cpuClkEn;
      p += periClkEn;
    end
  endtask
  task automatic busCyc(input logic isWr, input int waits);
    @(posedge clk_sys);
    busCsReq <= 1;
    busRead <= !isWr;
    busWrite <= isWr;
    busWrStrobe <= isWr;
    repeat (waits + 1) @(posedge clk_sys);
    busSecondState <= 1;
    @(posedge clk_sys);
    busSecondState <= 0;
    busWrStrobe <= 0;
    repeat (2) @(posedge clk_sys);
    while (busStall) @(posedge clk_sys);
    busCsReq <= 0;
    while (csOut) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask
  // A negative expectation is an upper bound, used where the slow clock's phase is free.
  task automatic csRun(input logic [2:0] sel, input logic [7:0] ps, input logic isWr,
                       input int eLen, input int eFall);
    int w;
    wr(8'h00, {3'h0, sel, 2'h0});
    wr(8'h0d, ps);
    tmp = rnd();
    w = tmp[1:0];
    busCyc(isWr, w);
    if (eLen < 0) chk(csLen > 0 && csLen <= -eLen, 1);
    else chk(csLen, eLen ? eLen : w + 4);
    if (eFall < 0) chk(csAtFall > 0 && csAtFall <= -eFall, 1);
    else if (eFall > 0) chk(csAtFall, eFall);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 0;
    chkRd(8'h00, 8'hc0);
    chkRd(8'h00, 8'h00);
    chkRd(8'h0d, 8'h00);
    chkRd(8'h20, 8'h00, 2'h2);
    $display("reset and map test done");
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, {3'h0, s[2:0], s[1:0]});
      chkRd(8'h00, {3'h0, s[2:0], s[1:0]});
      chk(periodicPriority, s[1:0]);
      chk({mainOscEn, slowClkMode}, {s != 5, s == 4 || s == 5});
      if (s != 4 && s != 5) begin
        cnt(48);
        chk(c, 48 / dv(s));
        chk(p, s == 1 ? 48 : 48 / dv(s));
      end
    end
    $display("clock select test done");
    wr(8'h12, 8'h07);
    wr(8'h00, 8'h21);
    repeat (2) @(posedge clk_sys);
    chk(forceCnt, 1);
    chkRd(8'h00, 8'h01);
    chkRd(8'h40 >> 2, 8'h04);
    chk(irq, 1);
    wr(8'h11, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    wr(8'h12, 8'h00);
    wdTimeout <= 1;
    @(posedge clk_sys);
    wdTimeout <= 0;
    repeat (3) @(posedge clk_sys);
    chk(irq, 0);
    chkRd(8'h00, 8'h41);
    wr(8'h0d, 8'h21);
    chkRd(8'h0d, 8'h21);
    chkRd(8'h10, 8'h03);
    wr(8'h11, 8'h07);
    chkRd(8'h10, 8'h00);
    $display("interrupt test done");
    for (int s = 0; s < 8; s++) if (s != 2 && s != 4 && s != 5) begin
      csRun(s[2:0], 8'h10, 0, 2, 0);
      csRun(s[2:0], 8'h08, 1, 4, 2);
    end
    csRun(3'h2, 8'h18, 0, 0, 0);
    csRun(3'h2, 8'h18, 1, 0, 0);
    csRun(3'h0, 8'h80, 0, 0, 0);
    csRun(3'h4, 8'h21, 0, 0, 0);
    for (int k = 4; k < 8; k++) csRun(3'h4, {k[2:0], 5'h0}, 0, k < 6 ? 3 : 2, 0);
    for (int k = 3; k < 8; k++) begin
      dvB = k == 3 ? 8'h00 : {5'h0, k[2:0]};
      per = 20 << (k - 3);
      wr(8'h00, 8'h10);
      wr(8'h0d, dvB);
      cnt(640);
      chk(c, 32 >> (k - 3));
      csRun(3'h5, 8'h10 | dvB, 0, -(per + 2), 0);
      csRun(3'h4, 8'h08 | dvB, 1, -(2 * per + 4), -(per + 2));
    end
    $display("chip select test done");
    completeRun();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    failCount++;
    completeRun();
  end
endmodule // power_save_clock_and_short_cs_bench
`default_nettype wire
